// [shared/pebc_pkg.sv]
package pebc_pkg;

  // ==========================================
  // Widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_W = 6;

  // ==========================================
  // Timing in own units, clock 10 MHz
  localparam int CLK_KHZ = 10000;
  localparam int PROGRAM_CYCLE_TIME_US = 5000;
  localparam int POWERUP_WRITE_DELAY_US = 5000;
  localparam int STROBE_WIDTH_NS = 50;
  localparam int ADDR_HOLD_NS = 50;
  localparam int STROBE_RECOVER_NS = 50;
  localparam int READ_ACCESS_NS = 120;
  localparam int BYTE_LOAD_MAX_NS = 100000;
  localparam int CLK_PERIOD_NS = 100;

  // Least times round up, longest round down, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_dn

  localparam int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * (CLK_KHZ / 1000);
  localparam int POWERUP_CYCLES = POWERUP_WRITE_DELAY_US * (CLK_KHZ / 1000);
  localparam int STROBE_CYCLES = cyc_up(STROBE_WIDTH_NS);
  localparam int HOLD_CYCLES = cyc_up(ADDR_HOLD_NS);
  localparam int RECOVER_CYCLES = cyc_up(STROBE_RECOVER_NS);
  localparam int READ_CYCLES = cyc_up(READ_ACCESS_NS) + 1;
  localparam int BYTE_LOAD_CYCLES = cyc_dn(BYTE_LOAD_MAX_NS);
  localparam int CNT_W = 16;

  // ==========================================
  // Reset values of pins
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ==========================================
  // Carriers
  typedef enum logic [1:0] {
    PEBC_OP_READ,
    PEBC_OP_WRITE,
    PEBC_OP_PAGE_END
  } pebc_op_t;

  typedef struct packed {
    pebc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic poll;
  } pebc_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
  } pebc_pins_t;

endpackage : pebc_pkg

// [rtl/pebc_page_buf.sv]
`timescale 1ns/10ps
module pebc_page_buf
  import pebc_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Write side
  input wire logic wr_en,
  input wire logic [PAGE_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  // Read side
  input wire logic [PAGE_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [PAGE_BYTES];

  // ==========================================
  // Registered read
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule : pebc_page_buf

// [rtl/pebc_host.sv]
`timescale 1ns/10ps
// Summary of operation
// - Without polling host waits full program cycle before dependent access.
// - Byte loads are strobe-controlled, spaced 0.15 to 100 us apart.
// - Between loads the gate stays high; polling starts only after the last load.
// - Each poll runs as a normal read cycle with read timing.
// - Toggle poll compares two reads; never assumes a start level.
// - No write within 5 ms of reset release.
// - A page write sequence runs to its end without other operations.
module pebc_host
  import pebc_pkg::*;
#(
  parameter int PROGRAM_CYC = PROGRAM_CYCLES,
  parameter int POWERUP_CYC = POWERUP_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire pebc_req_t req,
  // User answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  output logic busy,
  // Device pins
  output pebc_pins_t pins,
  input wire logic [DATA_W-1:0] dq_in
);

  typedef enum logic [3:0] {
    S_POWERUP, S_IDLE, S_RD_ACT, S_RD_END, S_WR_SETUP, S_WR_PULSE,
    S_WR_HOLD, S_LOAD_WAIT, S_PROG_WAIT, S_POLL_A, S_POLL_B, S_POLL_CMP
  } pebc_state_t;

  pebc_state_t state, next_state;
  pebc_pins_t next_pins;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] wait_cnt, next_wait_cnt;
  logic [DATA_W-1:0] first_rd, next_first_rd;
  logic [DATA_W-1:0] next_rsp_data;
  logic next_rsp_valid, next_rsp_timeout;
  logic use_poll, next_use_poll;
  logic [PAGE_W-1:0] load_idx, next_load_idx;
  logic [DATA_W-1:0] buf_rd;

  // Page store, replays each loaded byte onto the data pins
  pebc_page_buf u_buf (
    .mclk(mclk),
    .wr_en(req_valid && req_ready && req.op == PEBC_OP_WRITE),
    .wr_idx(load_idx),
    .wr_data(req.data),
    .rd_idx(load_idx),
    .rd_data(buf_rd)
  );

  function automatic logic [CNT_W-1:0] cw(input int v);
    return v[CNT_W-1:0];
  endfunction : cw

  // Page loads only while the page is still open, so no byte is taken and dropped
  assign req_ready = (state == S_IDLE)
                     || (state == S_LOAD_WAIT && wait_cnt != '0 && load_idx != '0
                         && req.op != PEBC_OP_READ);
  assign busy = (state != S_IDLE);

  // ==========================================
  // Next state
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_cnt = (cnt == '0) ? cnt : cnt - 16'h0001;
    next_wait_cnt = (wait_cnt == '0) ? wait_cnt : wait_cnt - 16'h0001;
    next_first_rd = first_rd;
    next_rsp_data = rsp_data;
    next_rsp_valid = 1'b0;
    next_rsp_timeout = rsp_timeout;
    next_use_poll = use_poll;
    next_load_idx = load_idx;
    case (state)
      S_POWERUP: begin
        if (cnt == '0) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        next_pins.ce_n = STROBE_IDLE;
        next_pins.oe_n = STROBE_IDLE;
        next_pins.we_n = STROBE_IDLE;
        next_pins.dq_oe_n = 1'b1;
        if (req_valid) begin
          next_pins.addr = req.addr;
          next_rsp_timeout = 1'b0;
          if (req.op == PEBC_OP_READ) begin
            next_pins.ce_n = 1'b0;
            next_pins.oe_n = 1'b0;
            next_cnt = cw(READ_CYCLES);
            next_state = S_RD_ACT;
          end else if (req.op == PEBC_OP_WRITE) begin
            next_use_poll = req.poll;
            next_load_idx = '0;
            next_pins.dq_out = req.data;
            next_pins.ce_n = 1'b0;
            next_state = S_WR_SETUP;
          end
        end
      end
      S_RD_ACT: begin
        if (cnt == '0) begin
          next_rsp_data = dq_in;
          next_rsp_valid = 1'b1;
          next_pins.oe_n = 1'b1;
          next_pins.ce_n = 1'b1;
          next_cnt = cw(RECOVER_CYCLES);
          next_state = S_RD_END;
        end
      end
      S_RD_END: begin
        if (cnt == '0) begin
          next_state = S_IDLE;
        end
      end
      S_WR_SETUP: begin
        next_pins.dq_oe_n = 1'b0;
        next_pins.we_n = 1'b0;
        next_cnt = cw(STROBE_CYCLES);
        next_state = S_WR_PULSE;
      end
      S_WR_PULSE: begin
        next_pins.dq_out = buf_rd;
        if (cnt == '0) begin
          next_pins.we_n = 1'b1;
          next_cnt = cw(HOLD_CYCLES);
          next_state = S_WR_HOLD;
        end
      end
      S_WR_HOLD: begin
        if (cnt == '0) begin
          next_pins.ce_n = 1'b1;
          next_pins.dq_oe_n = 1'b1;
          next_load_idx = load_idx + 6'h01;
          next_wait_cnt = cw(BYTE_LOAD_CYCLES) - cw(HOLD_CYCLES + 1);
          next_state = S_LOAD_WAIT;
        end
      end
      S_LOAD_WAIT: begin
        // Only page bytes or page end accepted here
        if ((req_valid && req.op == PEBC_OP_PAGE_END) || wait_cnt == '0
            || load_idx == '0) begin
          next_cnt = cw(PROGRAM_CYC);
          // Leftover load timer must not stretch the first poll read
          next_wait_cnt = '0;
          next_load_idx = '0;
          next_state = use_poll ? S_POLL_A : S_PROG_WAIT;
        end else if (req_valid && req.op == PEBC_OP_WRITE) begin
          next_pins.addr = req.addr;
          next_pins.dq_out = req.data;
          next_pins.ce_n = 1'b0;
          next_state = S_WR_SETUP;
        end
      end
      S_PROG_WAIT: begin
        if (cnt == '0) begin
          next_rsp_valid = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_POLL_A, S_POLL_B: begin
        if (!pins.oe_n) begin
          if (wait_cnt == '0) begin
            next_pins.oe_n = 1'b1;
            next_pins.ce_n = 1'b1;
            if (state == S_POLL_A) begin
              next_first_rd = dq_in;
              next_state = S_POLL_B;
            end else begin
              next_rsp_data = dq_in;
              next_state = S_POLL_CMP;
            end
            next_wait_cnt = cw(RECOVER_CYCLES);
          end
        end else if (wait_cnt == '0) begin
          // Strobes fall only when a full read count starts
          next_pins.ce_n = 1'b0;
          next_pins.oe_n = 1'b0;
          next_wait_cnt = cw(READ_CYCLES);
        end
      end
      S_POLL_CMP: begin
        if (first_rd[6] == rsp_data[6]) begin
          next_rsp_valid = 1'b1;
          next_state = S_IDLE;
        end else if (cnt == '0) begin
          next_rsp_valid = 1'b1;
          next_rsp_timeout = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_state = S_POLL_A;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_POWERUP;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: DATA_RESET,
                 dq_oe_n: 1'b1};
      cnt <= POWERUP_CYC[CNT_W-1:0];
      wait_cnt <= '0;
      first_rd <= DATA_RESET;
      rsp_data <= DATA_RESET;
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      use_poll <= 1'b0;
      load_idx <= '0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      cnt <= next_cnt;
      wait_cnt <= next_wait_cnt;
      first_rd <= next_first_rd;
      rsp_data <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
      rsp_timeout <= next_rsp_timeout;
      use_poll <= next_use_poll;
      load_idx <= next_load_idx;
    end
  end

endmodule : pebc_host

// [testbench/pebc_host_props.sv]
`timescale 1ns/10ps
module pebc_host_props
  import pebc_pkg::*;
#(
  parameter int PROGRAM_CYC = 50,
  parameter int POWERUP_CYC = 50
)
(
  // Clock and user side
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pebc_req_t req,
  input wire logic rsp_valid,
  input wire logic busy,
  // Device side
  input wire pebc_pins_t pins
);
  int pu;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pu <= 0;
    else if (pu < POWERUP_CYC) pu <= pu + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_standby_float: assert property (pins.ce_n |-> pins.dq_oe_n)
    else $error("data driven while deselected");
  a_read_mode: assert property (!pins.oe_n |-> pins.we_n && pins.dq_oe_n)
    else $error("gate low during write or drive");
  a_write_mode: assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n && !pins.dq_oe_n)
    else $error("bad write strobe mode");
  a_strobe_width: assert property ($fell(pins.we_n) |=> !pins.we_n ##1 $rose(pins.we_n))
    else $error("write strobe width wrong");
  a_strobe_recover: assert property ($rose(pins.we_n) |-> !pins.ce_n ##1 pins.we_n)
    else $error("write recovery too short");
  a_addr_hold: assert property (!pins.we_n |=> $stable(pins.addr))
    else $error("address moved at strobe end");
  a_read_timing: assert property ($fell(pins.oe_n) |-> (!pins.oe_n && !pins.ce_n)[*3])
    else $error("read cycle too short");
  a_read_answer: assert property (req_valid && req_ready && !busy && req.op == PEBC_OP_READ
    |-> ##[3:7] rsp_valid)
    else $error("read answer missing");
  a_powerup_wait: assert property (pu < POWERUP_CYC |-> pins.we_n)
    else $error("write during power-up wait");
endmodule : pebc_host_props
bind pebc_host pebc_host_props #(.PROGRAM_CYC(PROGRAM_CYC), .POWERUP_CYC(POWERUP_CYC)) u_props (
  .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .busy(busy), .pins(pins));

// [testbench/pebc_mem_model.sv]
`timescale 1ns/10ps
module pebc_mem_model
  import pebc_pkg::*;
#(
  parameter int PROG_NS = 3000
)
(
  input wire pebc_pins_t pins,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last_wr;
  logic prog;
  logic tog;
  int gen;
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) mem[i] = i[7:0] ^ 8'h5a;
    prog = 1'b0;
    tog = 1'b0;
    gen = 0;
    last_wr = 8'h00;
    dq = 8'h00;
  end
  always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n) begin
    mem[pins.addr] = din;
    last_wr = din;
    prog = 1'b1;
    gen++;
    fork
      begin
        automatic int g = gen;
        #PROG_NS;
        if (g == gen) prog = 1'b0;
      end
    join_none
  end
  // Toggle level is whatever it was last left at
  always @(negedge pins.oe_n) if (!pins.ce_n && prog) tog = ~tog;
  always @(pins.ce_n or pins.oe_n or pins.we_n or pins.addr or prog or tog) begin
    if (!pins.ce_n && !pins.oe_n && pins.we_n) begin
      dq = prog ? {~last_wr[7], tog, last_wr[5:0]} : mem[pins.addr];
    end else dq = ~dq;
  end
endmodule : pebc_mem_model

// [testbench/pebc_host_tb.sv]
`timescale 1ns/10ps
module pebc_host_tb;
  import pebc_pkg::*;
  logic mclk, rst_n, req_valid, req_ready, rsp_valid, rsp_timeout, busy;
  pebc_req_t req;
  pebc_pins_t pins;
  logic [DATA_W-1:0] rsp_data, dq_in, dev_dq, d;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] base;
  logic [31:0] seed;
  int n_errors, compares, n;
  assign dq_in = pins.dq_oe_n ? dev_dq : pins.dq_out;
  pebc_host #(.PROGRAM_CYC(50), .POWERUP_CYC(50)) dut (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .busy(busy), .pins(pins), .dq_in(dq_in));
  pebc_mem_model u_dev (.pins(pins), .din(dq_in), .dq(dev_dq));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] a);
    return shadow.exists(a) ? shadow[a] : (a[7:0] ^ 8'h5a);
  endfunction : exp_rd
  task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic send(input pebc_op_t op, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] dv, input logic p);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{op, a, dv, p};
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask : send
  task automatic wait_rsp(input int lim);
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (rsp_valid !== 1'b1 && i < lim);
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
  endtask : wait_rsp
  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    send(PEBC_OP_READ, a, 8'h00, 1'b0);
    wait_rsp(20);
    chk("rsp_data", exp_rd(a), rsp_data);
  endtask : rd_chk
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    seed = 32'h2ea6;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("req_ready", 8'h00, {7'h00, req_ready});
    chk("busy", 8'h01, {7'h00, busy});
    for (int p = 0; p < 3; p++) begin
      base = (p == 1) ? 13'h1fc0 : (ADDR_W'(rnd()) & 13'h1fc0);
      n = (p == 1) ? PAGE_BYTES : 1 + int'(rnd() % 4);
      for (int i = 0; i < n; i++) begin
        d = DATA_W'(rnd());
        shadow[base + ADDR_W'(i)] = d;
        send(PEBC_OP_WRITE, base + ADDR_W'(i), d, p[0]);
      end
      if (n < PAGE_BYTES && p != 2) send(PEBC_OP_PAGE_END, base, 8'h00, p[0]);
      wait_rsp(3000);
      chk("rsp_timeout", 8'h00, {7'h00, rsp_timeout});
      for (int i = 0; i < n; i++) rd_chk(base + ADDR_W'(i));
      rd_chk(ADDR_W'(rnd()));
    end
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule : pebc_host_tb
